// >>> hw/uaf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "uaf_regs.svh"

// Notes on behaviour
// - with filter mode on, non-address frames are dropped; receive buffer untouched.
// - transmitter works the same whatever the filter mode.
// - for 5 to 8 data bits the first stop bit gives the frame type.
// - for nine data bits the ninth received bit gives the frame type.
// - type bit one means address frame, zero means data frame.
// - mode on ignores data, also after an address, until a status write clears it; mode off receives normally.
// - an accepted address frame sets receive complete like any frame.
// - shared write: high bit zero loads baud high, one loads frame control.
// - shared read gives baud high, frame control if read the cycle before.
// - frame control read through the shared location shows select as one.
module uaf_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // received frames from the bit-recovery stage
    input wire logic rx_frame_valid,
    input wire uaf_pkg::uaf_rx_frame_s rx_frame,
    // transmitter side
    output logic tx_load,
    output uaf_pkg::uaf_tx_word_s tx_word,
    input wire logic tx_done,
    // configuration out to the serial engine
    output logic [2:0] char_size_code,
    output logic two_stop_select,
    output logic [6:0] baud_divider_high,
    output logic [6:0] frame_ctrl,
    // interrupt
    output logic irq
);
    import uaf_pkg::*;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_s_n;

    uaf_rst_sync u_rst (
        .clk(sys_clk),
        .arst_n(rst_n),
        .srst_n(rst_s_n)
    );

    // ----------------------------------------
    // bus handshake and decode
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    logic ack_q;
    logic [31:0] rdata_q;
    logic req;
    logic rd_acc;
    logic wr_acc;
    logic rd_first;
    logic lane0;
    logic sel_data;
    logic sel_status;
    logic sel_ctrlb;
    logic sel_shared;
    logic sel_istat;
    logic sel_imask;

    // one wait cycle per access: data is latched on the first edge, handed over on the second
    assign req = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_q;
    assign rd_acc = avs_read && ack_q;
    assign wr_acc = avs_write && ack_q;
    assign rd_first = avs_read && !ack_q;
    assign lane0 = avs_byteenable[0];
    assign sel_data = hit(avs_address, `UAF_OFF_DATA);
    assign sel_status = hit(avs_address, `UAF_OFF_STATUS);
    assign sel_ctrlb = hit(avs_address, `UAF_OFF_CTRLB);
    assign sel_shared = hit(avs_address, `UAF_OFF_SHARED);
    assign sel_istat = hit(avs_address, `UAF_OFF_IRQ_STAT);
    assign sel_imask = hit(avs_address, `UAF_OFF_IRQ_MASK);

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic filter_mode_q;
    logic rx_en_q;
    logic size2_q;
    logic tx9_q;
    logic txc_q;
    logic [6:0] baud_q;
    logic [6:0] fc_q;
    logic prev_sh_rd_q;
    logic rxc_q;
    logic [7:0] rx_data_q;
    logic rx9_q;
    logic fe_q;
    logic pe_q;
    logic ovr_q;
    logic [`UAF_IRQ_W-1:0] istat_q;
    logic [`UAF_IRQ_W-1:0] imask_q;
    logic tx_load_q;
    uaf_tx_word_s tx_word_q;

    logic wr_data;
    logic wr_status;
    logic wr_ctrlb;
    logic wr_shared;
    logic wr_istat;
    logic wr_imask;
    logic wr_baud;
    logic wr_fc;

    assign wr_data = wr_acc && lane0 && sel_data;
    assign wr_status = wr_acc && lane0 && sel_status;
    assign wr_ctrlb = wr_acc && lane0 && sel_ctrlb;
    assign wr_shared = wr_acc && lane0 && sel_shared;
    assign wr_istat = wr_acc && lane0 && sel_istat;
    assign wr_imask = wr_acc && lane0 && sel_imask;
    assign wr_baud = wr_shared && !avs_writedata[`UAF_SEL_BIT];
    assign wr_fc = wr_shared && avs_writedata[`UAF_SEL_BIT];

    // ----------------------------------------
    // frame filter
    // ----------------------------------------
    logic ninth_mode;
    logic is_addr;
    logic keep;
    logic accept;
    logic drop;
    logic rd_rx;

    assign char_size_code = {size2_q, fc_q[`UAF_FC_SZ_HI:`UAF_FC_SZ_LO]};
    assign ninth_mode = (char_size_code == `UAF_SZ_NINE);

    uaf_addr_filter u_filt (
        .frame(rx_frame),
        .ninth_mode(ninth_mode),
        .filter_mode(filter_mode_q),
        .is_addr(is_addr),
        .keep(keep)
    );

    // a dropped frame never reaches the buffer or its flags
    assign accept = rx_frame_valid && rx_en_q && keep;
    assign drop = rx_frame_valid && rx_en_q && !keep;
    assign rd_rx = rd_acc && sel_data;

    // ----------------------------------------
    // receive buffer and status
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            rxc_q <= 1'b0;
            rx_data_q <= 8'h00;
            rx9_q <= 1'b0;
            fe_q <= 1'b0;
            pe_q <= 1'b0;
            ovr_q <= 1'b0;
        end else if (!rx_en_q) begin
            rxc_q <= 1'b0;
            fe_q <= 1'b0;
            pe_q <= 1'b0;
            ovr_q <= 1'b0;
        end else if (accept) begin
            // set wins over the clear by a read in the same cycle
            rxc_q <= 1'b1;
            rx_data_q <= rx_frame.data;
            rx9_q <= rx_frame.ninth;
            fe_q <= rx_frame.frame_err;
            pe_q <= rx_frame.parity_err;
            ovr_q <= rxc_q && !rd_rx;
        end else if (rd_rx) begin
            rxc_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            filter_mode_q <= 1'b0;
            rx_en_q <= 1'b0;
            size2_q <= 1'b0;
            tx9_q <= 1'b0;
            baud_q <= `UAF_BAUD_RST;
            fc_q <= `UAF_FC_RST;
            imask_q <= '0;
        end else begin
            if (wr_status) filter_mode_q <= avs_writedata[`UAF_ST_MODE];
            if (wr_ctrlb) begin
                rx_en_q <= avs_writedata[`UAF_CB_RXEN];
                size2_q <= avs_writedata[`UAF_CB_SZ2];
                tx9_q <= avs_writedata[`UAF_CB_TX9];
            end
            if (wr_baud) baud_q <= avs_writedata[6:0];
            if (wr_fc) fc_q <= avs_writedata[6:0];
            if (wr_imask) imask_q <= avs_writedata[`UAF_IRQ_W-1:0];
        end
    end

    // ----------------------------------------
    // transmitter hand-off, blind to the filter mode
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            tx_load_q <= 1'b0;
            tx_word_q <= '0;
            txc_q <= 1'b0;
        end else begin
            tx_load_q <= wr_data;
            if (wr_data) tx_word_q <= {tx9_q, avs_writedata[7:0]};
            // completion wins over a write-one clear
            txc_q <= tx_done || (txc_q && !(wr_status && avs_writedata[`UAF_ST_TXC]));
        end
    end

    assign tx_load = tx_load_q;
    assign tx_word = tx_word_q;
    assign two_stop_select = fc_q[`UAF_FC_STOP2];
    assign baud_divider_high = baud_q;
    assign frame_ctrl = fc_q;

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    logic [`UAF_IRQ_W-1:0] ev;
    logic [`UAF_IRQ_W-1:0] iclr;

    assign ev = {accept && rxc_q && !rd_rx, tx_done, drop, accept};
    assign iclr = wr_istat ? avs_writedata[`UAF_IRQ_W-1:0] : '0;

    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            istat_q <= '0;
        end else begin
            istat_q <= ev | (istat_q & ~iclr);
        end
    end

    assign irq = |(istat_q & imask_q);

    // ----------------------------------------
    // read path and shared location sequence
    // ----------------------------------------
    logic [7:0] status_rd;
    logic [7:0] ctrlb_rd;
    logic [7:0] shared_rd;
    logic [31:0] rd_mux;

    assign status_rd = {rxc_q, txc_q, 1'b0, fe_q, ovr_q, pe_q, 1'b0, filter_mode_q};
    assign ctrlb_rd = {3'h0, rx_en_q, 1'b0, size2_q, rx9_q, tx9_q};
    // a shared read accepted on the edge just before picks frame control
    assign shared_rd = prev_sh_rd_q ? {1'b1, fc_q} : {1'b0, baud_q};
    assign rd_mux = sel_data ? {24'h0, rx_data_q} :
                    sel_status ? {24'h0, status_rd} :
                    sel_ctrlb ? {24'h0, ctrlb_rd} :
                    sel_shared ? {24'h0, shared_rd} :
                    sel_istat ? {28'h0, istat_q} :
                    sel_imask ? {28'h0, imask_q} : 32'h0;

    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
            prev_sh_rd_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
            if (rd_first) rdata_q <= rd_mux;
            prev_sh_rd_q <= rd_acc && sel_shared;
        end
    end

    assign avs_readdata = rdata_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    drop_keeps_buf_a: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
        (rx_frame_valid && filter_mode_q && !is_addr) |=> $stable(rx_data_q))
        else $error("dropped frame changed the receive buffer");
    drop_no_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
        (drop && !rxc_q) |=> !rxc_q && $stable({fe_q, pe_q, ovr_q}))
        else $error("dropped frame raised a receive flag");
    addr_sets_rxc_a: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
        (rx_frame_valid && rx_en_q && is_addr) |=> rxc_q && rx_data_q == $past(rx_frame.data))
        else $error("address frame not stored with complete flag");
    nine_type_a: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
        (rx_frame_valid && ninth_mode) |-> is_addr == rx_frame.ninth)
        else $error("ninth bit not used as frame type");
    stop_type_a: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
        (rx_frame_valid && !ninth_mode) |-> is_addr == rx_frame.stop1)
        else $error("stop bit not used as frame type");
    open_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
        (rx_frame_valid && rx_en_q && !filter_mode_q) |-> accept)
        else $error("addressed slave dropped a frame");
    tx_blind_a: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
        (avs_write && !avs_waitrequest && lane0 && sel_data) |=> tx_load && tx_word.data == $past(avs_writedata[7:0]))
        else $error("transmit load missed");
    baud_write_a: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
        wr_baud |=> baud_q == $past(avs_writedata[6:0]) && $stable(fc_q))
        else $error("baud high write misrouted");
    fc_write_a: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
        wr_fc |=> fc_q == $past(avs_writedata[6:0]) && $stable(baud_q))
        else $error("frame control write misrouted");
    pair_read_a: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
        (rd_acc && sel_shared) ##1 (rd_first && sel_shared) |=> avs_readdata[7:0] == {1'b1, $past(fc_q)})
        else $error("second shared read did not give frame control");
    single_read_a: assert property (@(posedge sys_clk) disable iff (!rst_s_n)
        (!prev_sh_rd_q && rd_first && sel_shared) |=> avs_readdata[7:0] == {1'b0, $past(baud_q)})
        else $error("lone shared read did not give baud high");
endmodule

`default_nettype wire

// >>> hw/uaf_regs.svh
`ifndef UAF_REGS_SVH
`define UAF_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define UAF_OFF_DATA 8'h00
`define UAF_OFF_STATUS 8'h04
`define UAF_OFF_CTRLB 8'h08
`define UAF_OFF_SHARED 8'h0C
`define UAF_OFF_IRQ_STAT 8'h10
`define UAF_OFF_IRQ_MASK 8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define UAF_ST_RXC 7
`define UAF_ST_TXC 6
`define UAF_ST_FE 4
`define UAF_ST_OVR 3
`define UAF_ST_PE 2
`define UAF_ST_MODE 0
`define UAF_CB_RXEN 4
`define UAF_CB_SZ2 2
`define UAF_CB_RX9 1
`define UAF_CB_TX9 0
`define UAF_SEL_BIT 7
`define UAF_FC_SZ_HI 2
`define UAF_FC_SZ_LO 1
`define UAF_FC_STOP2 3
`define UAF_IRQ_ACC 0
`define UAF_IRQ_DROP 1
`define UAF_IRQ_TXC 2
`define UAF_IRQ_OVR 3

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define UAF_FC_RST 7'h06
`define UAF_BAUD_RST 7'h00
`define UAF_SZ_NINE 3'h7
`define UAF_IRQ_W 4

`endif

// >>> hw/uaf_pkg.sv
package uaf_pkg;

    // one received frame as handed over by the bit-recovery stage
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic stop1;
        logic frame_err;
        logic parity_err;
    } uaf_rx_frame_s;

    // word handed to the transmitter
    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } uaf_tx_word_s;

endpackage

// >>> hw/uaf_rst_sync.sv
`timescale 1ns/1ps
`default_nettype none

module uaf_rst_sync (
    // clock and raw reset
    input wire logic clk,
    input wire logic arst_n,
    // released reset
    output logic srst_n
);
    logic stage_q;
    logic out_q;

    // assert at once, release two edges later
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            stage_q <= 1'b1;
            out_q <= stage_q;
        end
    end

    assign srst_n = out_q;
endmodule

`default_nettype wire

// >>> hw/uaf_addr_filter.sv
`timescale 1ns/1ps
`default_nettype none

module uaf_addr_filter (
    // frame and mode
    input wire uaf_pkg::uaf_rx_frame_s frame,
    input wire logic ninth_mode,
    input wire logic filter_mode,
    // decision
    output logic is_addr,
    output logic keep
);
    import uaf_pkg::*;

    // ninth bit marks the type in 9-bit frames, first stop bit otherwise
    assign is_addr = ninth_mode ? frame.ninth : frame.stop1;
    // an addressed slave has the mode off and takes everything
    assign keep = !filter_mode || is_addr;
endmodule

`default_nettype wire

// >>> test/uaf_frame_src.sv
`timescale 1ns/1ps
`default_nettype none

module uaf_frame_src (
    // clock
    input wire logic clk,
    // frames toward the receiver
    output logic rx_frame_valid,
    output uaf_pkg::uaf_rx_frame_s rx_frame,
    // transmitter handshake
    input wire logic tx_load,
    output logic tx_done
);
    import uaf_pkg::*;
    // ----------------------------------------
    // line model
    // ----------------------------------------
    logic [3:0] cnt_q;
    initial begin
        rx_frame_valid = 1'b0;
        rx_frame = '0;
        tx_done = 1'b0;
        cnt_q = 4'h0;
    end
    // one frame per call; type bit as the sender sets it
    task automatic send(input uaf_rx_frame_s f);
        rx_frame_valid <= 1'b1;
        rx_frame <= f;
        @(posedge clk);
        rx_frame_valid <= 1'b0;
        // outside a frame the lines show no stale value
        rx_frame <= ~f;
        @(posedge clk);
    endtask
    // a slow shifter: done four cycles after the load
    always @(posedge clk) begin
        tx_done <= (cnt_q == 4'h1);
        if (tx_load) begin
            cnt_q <= 4'h4;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule

`default_nettype wire

// >>> test/tb_uart_addr_filter_shared_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "uaf_regs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end

module tb_uart_addr_filter_shared_reg;
    import uaf_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
    logic avs_waitrequest, rx_frame_valid, tx_load, tx_done, two_stop_select, irq;
    uaf_rx_frame_s rx_frame;
    uaf_tx_word_s tx_word;
    logic [2:0] char_size_code;
    logic [6:0] baud_divider_high, frame_ctrl;
    int failures = 0, compares = 0, cycles = 0;

    uaf_top i_uaf_top (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(4'h1), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_frame_valid(rx_frame_valid),
        .rx_frame(rx_frame), .tx_load(tx_load), .tx_word(tx_word), .tx_done(tx_done),
        .char_size_code(char_size_code), .two_stop_select(two_stop_select),
        .baud_divider_high(baud_divider_high), .frame_ctrl(frame_ctrl), .irq(irq));
    uaf_frame_src i_uaf_frame_src (.clk(sys_clk), .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame),
        .tx_load(tx_load), .tx_done(tx_done));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // closing and hang guard
    // ----------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            end_sim();
        end
    end
    // ----------------------------------------
    // bus access
    // ----------------------------------------
    // hold keeps read high so the next read starts right after this acceptance
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd, input logic hold);
        avs_address <= a;
        avs_read <= ~we;
        avs_write <= we;
        avs_writedata <= wd;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        if (!hold) begin
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            // an idle edge keeps the next request out of this time step and lets the write land
            @(posedge sys_clk);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 1'b0);
        `CHK(rdata, exp)
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_shared;
        `CHK({baud_divider_high, frame_ctrl}, {`UAF_BAUD_RST, `UAF_FC_RST})
        bus(1'b1, `UAF_OFF_SHARED, 32'h05, 1'b0);
        bus(1'b1, `UAF_OFF_SHARED, 32'h8E, 1'b0);
        `CHK({baud_divider_high, frame_ctrl}, {7'h05, 7'h0E})
        `CHK({two_stop_select, char_size_code}, 4'hB)
        rd_chk(`UAF_OFF_SHARED, 32'h05);
        // two reads kept back to back
        bus(1'b0, `UAF_OFF_SHARED, 32'h0, 1'b1);
        `CHK(rdata, 32'h05)
        rd_chk(`UAF_OFF_SHARED, 32'h8E);
        rd_chk(8'h20, 32'h0);
        bus(1'b1, `UAF_OFF_SHARED, 32'h86, 1'b0);
    endtask
    task automatic t_stop_bit;
        bus(1'b1, `UAF_OFF_CTRLB, 32'h10, 1'b0);
        // whole-word writes, never bit set or clear
        bus(1'b1, `UAF_OFF_STATUS, 32'h01, 1'b0);
        i_uaf_frame_src.send({8'hA5, 1'b1, 1'b0, 1'b0, 1'b0});
        rd_chk(`UAF_OFF_STATUS, 32'h01);
        i_uaf_frame_src.send({8'h3C, 1'b0, 1'b1, 1'b0, 1'b0});
        rd_chk(`UAF_OFF_STATUS, 32'h81);
        // a data frame dropped while the buffer is full must not raise overrun
        i_uaf_frame_src.send({8'h77, 1'b0, 1'b0, 1'b0, 1'b0});
        rd_chk(`UAF_OFF_STATUS, 32'h81);
        rd_chk(`UAF_OFF_IRQ_STAT, 32'h03);
        rd_chk(`UAF_OFF_DATA, 32'h3C);
    endtask
    task automatic t_ninth_bit;
        bus(1'b1, `UAF_OFF_CTRLB, 32'h14, 1'b0);
        `CHK(char_size_code, `UAF_SZ_NINE)
        i_uaf_frame_src.send({8'h11, 1'b0, 1'b1, 1'b1, 1'b1});
        rd_chk(`UAF_OFF_STATUS, 32'h01);
        i_uaf_frame_src.send({8'h22, 1'b1, 1'b0, 1'b0, 1'b0});
        rd_chk(`UAF_OFF_CTRLB, 32'h16);
        rd_chk(`UAF_OFF_DATA, 32'h22);
        // selected slave leaves filter mode
        bus(1'b1, `UAF_OFF_STATUS, 32'h00, 1'b0);
        i_uaf_frame_src.send({8'h33, 1'b0, 1'b1, 1'b0, 1'b0});
        rd_chk(`UAF_OFF_STATUS, 32'h80);
        rd_chk(`UAF_OFF_DATA, 32'h33);
    endtask
    task automatic t_tx(input logic mode);
        bus(1'b1, `UAF_OFF_STATUS, {31'h0, mode}, 1'b0);
        bus(1'b1, `UAF_OFF_CTRLB, 32'h15, 1'b0);
        bus(1'b1, `UAF_OFF_DATA, 32'h5A, 1'b0);
        `CHK({tx_load, tx_word}, 10'h35A)
        repeat (6) @(posedge sys_clk);
        rd_chk(`UAF_OFF_STATUS, {24'h0, 7'h20, mode});
        bus(1'b1, `UAF_OFF_STATUS, {25'h0, 1'b1, 5'h0, mode}, 1'b0);
    endtask
    task automatic t_irq;
        bus(1'b1, `UAF_OFF_IRQ_STAT, 32'h0F, 1'b0);
        bus(1'b1, `UAF_OFF_IRQ_MASK, 32'h04, 1'b0);
        i_uaf_frame_src.send({8'h44, 1'b1, 1'b1, 1'b0, 1'b0});
        `CHK(irq, 1'b0)
        // empty the buffer so the status read in the transmit pass sees receive complete low
        rd_chk(`UAF_OFF_DATA, 32'h44);
        t_tx(1'b1);
        `CHK(irq, 1'b1)
        rd_chk(`UAF_OFF_IRQ_STAT, 32'h05);
        bus(1'b1, `UAF_OFF_IRQ_STAT, 32'h04, 1'b0);
        @(posedge sys_clk);
        `CHK(irq, 1'b0)
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_shared();
        t_stop_bit();
        t_ninth_bit();
        t_tx(1'b0);
        t_irq();
        end_sim();
    end
endmodule

`default_nettype wire
